// ### core/dcca_pkg.sv
// shared constants, enumerations and carrier structs for the capture/compare array
package dcca_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NUM_UNITS   = 2;   // independent capture/compare units
	localparam int CH_PER_UNIT = 16;  // channels in one unit
	localparam int NUM_CH      = 32;  // channels in the whole block
	localparam int TMR_PER_UNIT = 2;  // time bases in one unit
	localparam int NUM_TMR     = 4;   // time bases in the whole block
	localparam int TMR_W       = 16;  // timer and channel register width
	localparam int DIV_SEL_W   = 3;   // prescale selection field width
	localparam int PSC_W       = 10;  // prescale counter width, largest divide 1024
	localparam int DBL_PAIRS   = 8;   // double register pairs in one unit
	localparam int DBL_OFS     = 8;   // partner channel sits this far above

	// divide factor is 2**(code + PSC_SHIFT_BASE): 000b gives 8, 111b gives 1024
	localparam logic [3:0]       PSC_SHIFT_BASE = 4'h3;
	localparam logic [PSC_W:0]   PSC_ONE        = 11'h001;
	localparam logic [TMR_W-1:0] TMR_MAX        = 16'hFFFF;
	localparam logic [TMR_W-1:0] TMR_CLR        = 16'h0000;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	// channel operating mode
	typedef enum logic [2:0] {
		DCCA_OFF      = 3'h0,  // channel disabled, pin released
		DCCA_CAP_RISE = 3'h1,  // capture on rising pin edge
		DCCA_CAP_FALL = 3'h2,  // capture on falling pin edge
		DCCA_CAP_BOTH = 3'h3,  // capture on either edge
		DCCA_CMP0     = 3'h4,  // interrupt on every match
		DCCA_CMP1     = 3'h5,  // toggle pin on every match
		DCCA_CMP2     = 3'h6,  // interrupt once per period
		DCCA_CMP3     = 3'h7   // set pin on match, clear on overflow
	} dcca_mode_t;

	// timer count source
	typedef enum logic [1:0] {
		DCCA_SRC_PSC = 2'h0,  // prescaled system clock
		DCCA_SRC_GT6 = 2'h1,  // general_timer_six overflow/underflow pulse
		DCCA_SRC_EXT = 2'h2,  // external count input, timer a of each unit only
		DCCA_SRC_OFF = 2'h3   // no count source
	} dcca_src_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	// per channel configuration
	typedef struct packed {
		dcca_mode_t mode;  // operating mode
		logic       tsel;  // 0: timer a of the unit, 1: timer b
	} dcca_ch_cfg_t;

	// per timer configuration
	typedef struct packed {
		logic                 run;     // count enable
		dcca_src_t            src;     // count source
		logic [DIV_SEL_W-1:0] div;     // timer_input_select prescale code
		logic [TMR_W-1:0]     reload;  // value loaded on overflow
	} dcca_tmr_cfg_t;

endpackage

// ### core/dcca_timer.sv
// one reloadable 16-bit time base with its prescaler
`timescale 1ns/100ps
module dcca_timer #(
	parameter bit EXT_OK = 1'b0  // external count input available
) (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_nrst,
	input  dcca_pkg::dcca_tmr_cfg_t     i_cfg,
	input  wire logic                   i_gt6_ovf,
	input  wire logic                   i_ext_pulse,
	output logic [dcca_pkg::TMR_W-1:0]  o_count,
	output logic                        o_step,
	output logic                        o_ovf
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [dcca_pkg::PSC_W-1:0] psc;   // prescale divider
		logic [dcca_pkg::TMR_W-1:0] cnt;   // timer value
		logic                       step;  // cnt changed this edge
		logic                       ovf;   // cnt wrapped this edge
	} dcca_tmr_state_t;

	dcca_tmr_state_t q;  // registered state
	dcca_tmr_state_t d;  // next state

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// a stopped timer also clears its prescaler so a restart gets a full first tick
	always_comb
	begin
		logic                       tick;
		logic [3:0]                 shift;
		logic [dcca_pkg::PSC_W:0]   lim;
		d      = q;
		tick   = 1'b0;
		shift  = 4'(i_cfg.div) + dcca_pkg::PSC_SHIFT_BASE;
		lim    = (dcca_pkg::PSC_ONE << shift) - dcca_pkg::PSC_ONE;
		d.step = 1'b0;
		d.ovf  = 1'b0;
		if (!i_cfg.run)
			d.psc = '0;
		else
		begin
			case (i_cfg.src)
				dcca_pkg::DCCA_SRC_PSC:
				begin
					if (q.psc == lim[dcca_pkg::PSC_W-1:0])
					begin
						d.psc = '0;
						tick  = 1'b1;
					end
					else
						d.psc = q.psc + 1'b1;
				end
				dcca_pkg::DCCA_SRC_GT6: tick = i_gt6_ovf;
				dcca_pkg::DCCA_SRC_EXT: tick = EXT_OK & i_ext_pulse;
				default:                tick = 1'b0;
			endcase
		end
		// count up, reload on overflow; reload 0000h spans 65536 ticks
		if (tick)
		begin
			d.step = 1'b1;
			if (q.cnt == dcca_pkg::TMR_MAX)
			begin
				d.cnt = i_cfg.reload;
				d.ovf = 1'b1;
			end
			else
				d.cnt = q.cnt + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// reset leaves the timer cleared
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			q <= '0;
		else
			q <= d;
	end

	assign o_count = q.cnt;
	assign o_step  = q.step;
	assign o_ovf   = q.ovf;

endmodule // dcca_timer

// ### core/dcca_array.sv
// two capture/compare units with their time bases, channels and pins
`timescale 1ns/100ps

module dcca_array (
	input  wire logic                                        i_sys_clk,
	input  wire logic                                        i_nrst,
	input  dcca_pkg::dcca_tmr_cfg_t [dcca_pkg::NUM_TMR-1:0]  i_tmr_cfg,
	input  dcca_pkg::dcca_ch_cfg_t  [dcca_pkg::NUM_CH-1:0]   i_ch_cfg,
	input  wire logic [dcca_pkg::NUM_UNITS*dcca_pkg::DBL_PAIRS-1:0] i_dbl_en,
	input  wire logic [dcca_pkg::NUM_CH-1:0]                 i_ch_wr,
	input  wire logic [dcca_pkg::TMR_W-1:0]                  i_ch_wr_data,
	input  wire logic                                        i_gt6_ovf,
	input  wire logic [dcca_pkg::NUM_UNITS-1:0]              i_ext_cnt,
	input  wire logic [dcca_pkg::NUM_CH-1:0]                 i_pin_in,
	output logic [dcca_pkg::NUM_CH-1:0]                      o_pin_out,
	output logic [dcca_pkg::NUM_CH-1:0]                      o_pin_oe_n,
	output logic [dcca_pkg::NUM_CH-1:0][dcca_pkg::TMR_W-1:0] o_ch_value,
	output logic [dcca_pkg::NUM_CH-1:0]                      o_ch_irq,
	output logic [dcca_pkg::NUM_TMR-1:0][dcca_pkg::TMR_W-1:0] o_tmr_count,
	output logic [dcca_pkg::NUM_TMR-1:0]                     o_tmr_ovf
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	// one channel register with its pin and bookkeeping
	typedef struct packed {
		logic [dcca_pkg::TMR_W-1:0] value;  // capture result or compare value
		logic                       pin;    // pin output level
		logic                       irq;    // one-cycle interrupt request
		logic                       done;   // compare already fired this period
		logic                       prev;   // pin input one edge ago
	} dcca_ch_state_t;

	// whole block state
	typedef struct packed {
		logic [dcca_pkg::NUM_CH-1:0]                oe_n;      // pin released when high
		dcca_ch_state_t [dcca_pkg::NUM_CH-1:0]      ch;        // channel registers
		logic [dcca_pkg::NUM_UNITS-1:0]             ext_prev;  // external count input history
		logic [dcca_pkg::NUM_UNITS-1:0]             ext_rise;  // registered count edge
	} dcca_state_t;

	dcca_state_t q;  // registered state
	dcca_state_t d;  // next state

	// timer outputs seen by the channels
	logic [dcca_pkg::NUM_TMR-1:0][dcca_pkg::TMR_W-1:0] tmr_cnt;
	logic [dcca_pkg::NUM_TMR-1:0]                      tmr_step;
	logic [dcca_pkg::NUM_TMR-1:0]                      tmr_ovf;

	// ------------------------------------------------------------
	// time bases
	// ------------------------------------------------------------
	// timer a of each unit accepts the external count input
	genvar gt;
	generate
		for (gt = 0; gt < dcca_pkg::NUM_TMR; gt++)
		begin : g_tmr
			dcca_timer #(
				.EXT_OK ((gt % dcca_pkg::TMR_PER_UNIT) == 0)
			) u_tmr (
				.i_sys_clk   (i_sys_clk),
				.i_nrst      (i_nrst),
				.i_cfg       (i_tmr_cfg[gt]),
				.i_gt6_ovf   (i_gt6_ovf),
				.i_ext_pulse (q.ext_rise[gt / dcca_pkg::TMR_PER_UNIT]),
				.o_count     (tmr_cnt[gt]),
				.o_step      (tmr_step[gt]),
				.o_ovf       (tmr_ovf[gt])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// channel logic
	// ------------------------------------------------------------
	// matches are judged only on the edge after the timer stepped, so a
	// stopped timer sitting on a compare value does not fire every cycle
	always_comb
	begin
		logic [dcca_pkg::NUM_CH-1:0]  match;
		logic                         trig;
		logic                         rise;
		logic                         fall;
		int                           t;
		int                           j;
		logic [dcca_pkg::TMR_W-1:0]   cnt;
		logic                         step;
		logic                         ovf;
		dcca_pkg::dcca_mode_t         mode;
		d     = q;
		match = '0;
		trig  = 1'b0;
		rise  = 1'b0;
		fall  = 1'b0;
		t     = 0;
		j     = 0;
		cnt   = '0;
		step  = 1'b0;
		ovf   = 1'b0;
		mode  = dcca_pkg::DCCA_OFF;

		// external count inputs: rising edge counts
		for (int u = 0; u < dcca_pkg::NUM_UNITS; u++)
		begin
			d.ext_prev[u] = i_ext_cnt[u];
			d.ext_rise[u] = i_ext_cnt[u] & ~q.ext_prev[u];
		end

		for (int i = 0; i < dcca_pkg::NUM_CH; i++)
		begin
			// pick the assigned timer of this channel's unit
			t    = (i / dcca_pkg::CH_PER_UNIT) * dcca_pkg::TMR_PER_UNIT
			       + int'(i_ch_cfg[i].tsel);
			cnt  = tmr_cnt[t];
			step = tmr_step[t];
			ovf  = tmr_ovf[t];
			mode = i_ch_cfg[i].mode;
			rise = i_pin_in[i] & ~q.ch[i].prev;
			fall = ~i_pin_in[i] & q.ch[i].prev;
			trig = 1'b0;
			d.ch[i].prev = i_pin_in[i];
			d.ch[i].irq  = 1'b0;
			// a match exists only in the compare modes
			match[i] = mode[2] & step & (cnt == q.ch[i].value);

			case (mode)
				// capture: pin is an input, latch timer on selected edge
				dcca_pkg::DCCA_CAP_RISE,
				dcca_pkg::DCCA_CAP_FALL,
				dcca_pkg::DCCA_CAP_BOTH:
				begin
					trig = (mode != dcca_pkg::DCCA_CAP_FALL && rise)
					       || (mode != dcca_pkg::DCCA_CAP_RISE && fall);
					d.oe_n[i]   = 1'b1;
					d.ch[i].pin = 1'b0;
					if (trig)
					begin
						d.ch[i].value = cnt;
						d.ch[i].irq   = 1'b1;
					end
				end
				// interrupt on every match, pin left alone
				dcca_pkg::DCCA_CMP0:
				begin
					d.oe_n[i]   = 1'b1;
					d.ch[i].irq = match[i];
				end
				// toggle on every match
				dcca_pkg::DCCA_CMP1:
				begin
					d.oe_n[i] = 1'b0;
					if (match[i])
					begin
						d.ch[i].pin = ~q.ch[i].pin;
						d.ch[i].irq = 1'b1;
					end
				end
				// one interrupt per period, re-armed by overflow
				dcca_pkg::DCCA_CMP2:
				begin
					d.oe_n[i] = 1'b1;
					if (ovf)
						d.ch[i].done = 1'b0;
					if (match[i] && (ovf || !q.ch[i].done))
					begin
						d.ch[i].irq  = 1'b1;
						d.ch[i].done = 1'b1;
					end
				end
				// set on match, clear on overflow, once per period
				dcca_pkg::DCCA_CMP3:
				begin
					d.oe_n[i] = 1'b0;
					if (ovf)
					begin
						d.ch[i].pin  = 1'b0;
						d.ch[i].done = 1'b0;
					end
					if (match[i] && (ovf || !q.ch[i].done))
					begin
						d.ch[i].pin  = 1'b1;
						d.ch[i].irq  = 1'b1;
						d.ch[i].done = 1'b1;
					end
				end
				// disabled: pin released, bookkeeping idle
				default:
				begin
					d.oe_n[i]    = 1'b1;
					d.ch[i].pin  = 1'b0;
					d.ch[i].done = 1'b0;
				end
			endcase

			// software write loses to a capture in the same cycle
			if (i_ch_wr[i] && !trig)
				d.ch[i].value = i_ch_wr_data;
		end

		// double register: lower channel's pin toggled by either match,
		// upper channel's pin released; equal matches cancel out
		for (int u = 0; u < dcca_pkg::NUM_UNITS; u++)
		begin
			for (int k = 0; k < dcca_pkg::DBL_PAIRS; k++)
			begin
				t = u * dcca_pkg::CH_PER_UNIT + k;
				j = t + dcca_pkg::DBL_OFS;
				if (i_dbl_en[u * dcca_pkg::DBL_PAIRS + k])
				begin
					d.oe_n[t]    = 1'b0;
					d.ch[t].pin  = q.ch[t].pin ^ match[t] ^ match[j];
					d.ch[t].irq  = match[t];
					d.oe_n[j]    = 1'b1;
					d.ch[j].pin  = 1'b0;
					d.ch[j].irq  = match[j];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// reset: all pins released, channels cleared
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			q <= '{oe_n: '1, ch: '0, ext_prev: '0, ext_rise: '0};
		else
			q <= d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// every output below is a flip-flop of this block or of a timer
	generate
		for (gt = 0; gt < dcca_pkg::NUM_CH; gt++)
		begin : g_out
			assign o_pin_out[gt]  = q.ch[gt].pin;
			assign o_ch_value[gt] = q.ch[gt].value;
			assign o_ch_irq[gt]   = q.ch[gt].irq;
		end
	endgenerate

	assign o_pin_oe_n  = q.oe_n;
	assign o_tmr_count = tmr_cnt;
	assign o_tmr_ovf   = tmr_ovf;

endmodule // dcca_array

// ### testbench/dcca_array_asserts.sv
// port-level assertions for the capture/compare array
`timescale 1ns/100ps
module dcca_array_asserts (
	input  wire logic                                        i_sys_clk,
	input  wire logic                                        i_nrst,
	input  dcca_pkg::dcca_tmr_cfg_t [dcca_pkg::NUM_TMR-1:0]  i_tmr_cfg,
	input  dcca_pkg::dcca_ch_cfg_t  [dcca_pkg::NUM_CH-1:0]   i_ch_cfg,
	input  wire logic                                        i_gt6_ovf,
	input  wire logic [dcca_pkg::NUM_CH-1:0]                 i_pin_in,
	input  wire logic [dcca_pkg::NUM_CH-1:0]                 o_pin_out,
	input  wire logic [dcca_pkg::NUM_CH-1:0]                 o_pin_oe_n,
	input  wire logic [dcca_pkg::NUM_CH-1:0][dcca_pkg::TMR_W-1:0] o_ch_value,
	input  wire logic [dcca_pkg::NUM_CH-1:0]                 o_ch_irq,
	input  wire logic [dcca_pkg::NUM_TMR-1:0][dcca_pkg::TMR_W-1:0] o_tmr_count,
	input  wire logic [dcca_pkg::NUM_TMR-1:0]                o_tmr_ovf
);
	// ------------------------------------------------------------
	// properties, all on the system clock
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	// pins released and timers cleared as reset lets go
	property p_rst; $rose(i_nrst) |-> (&o_pin_oe_n) && (o_tmr_count == '0) && (o_ch_irq == '0); endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared at reset");
	// overflow only out of the top value, landing on the reload value
	property p_ovf; o_tmr_ovf[0] |-> o_tmr_count[0] == i_tmr_cfg[0].reload && $past(o_tmr_count[0]) == dcca_pkg::TMR_MAX; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow without reload");
	// a step that is not an overflow adds exactly one
	property p_inc; $changed(o_tmr_count[1]) && !o_tmr_ovf[1] |-> o_tmr_count[1] == $past(o_tmr_count[1]) + 16'h0001; endproperty
	a_inc: assert property (p_inc) else $error("timer step not plus one");
	// code zero divides by eight
	property p_psc; i_tmr_cfg[1].run && i_tmr_cfg[1].src == dcca_pkg::DCCA_SRC_PSC && i_tmr_cfg[1].div == 3'h0
		&& $changed(o_tmr_count[1]) |=> $stable(o_tmr_count[1]) [*7] ##1 $changed(o_tmr_count[1]); endproperty
	a_psc: assert property (p_psc) else $error("prescaled tick spacing wrong");
	// every timer-six pulse is one tick, and nothing else ticks
	property p_gt6; i_tmr_cfg[0].run && i_tmr_cfg[0].src == dcca_pkg::DCCA_SRC_GT6 |=> $changed(o_tmr_count[0]) == $past(i_gt6_ovf); endproperty
	a_gt6: assert property (p_gt6) else $error("timer six tick mismatch");
	// rising edge latches the count seen at the edge
	property p_cap_rise; $past(i_nrst) && i_ch_cfg[0].mode == dcca_pkg::DCCA_CAP_RISE && $rose(i_pin_in[0])
		|=> o_ch_irq[0] && o_ch_value[0] == $past(o_tmr_count[0]); endproperty
	a_cap_rise: assert property (p_cap_rise) else $error("rising capture missed");
	property p_cap_fall; $past(i_nrst) && i_ch_cfg[1].mode == dcca_pkg::DCCA_CAP_FALL && $fell(i_pin_in[1]) |=> o_ch_irq[1]; endproperty
	a_cap_fall: assert property (p_cap_fall) else $error("falling capture missed");
	// a toggling pin is driven and each toggle comes with its interrupt
	property p_tog; i_ch_cfg[5].mode == dcca_pkg::DCCA_CMP1 && $changed(o_pin_out[5]) |-> o_ch_irq[5] && !o_pin_oe_n[5]; endproperty
	a_tog: assert property (p_tog) else $error("toggle without match");
	property p_cmp0; i_ch_cfg[3].mode == dcca_pkg::DCCA_CMP0 && $changed(o_tmr_count[0]) && o_tmr_count[0] == o_ch_value[3]
		|=> o_ch_irq[3] && o_pin_oe_n[3]; endproperty
	a_cmp0: assert property (p_cmp0) else $error("interrupt-only match wrong");
	// match sets, overflow clears, otherwise the pin holds
	property p_cmp3; i_ch_cfg[4].mode == dcca_pkg::DCCA_CMP3 && $changed(o_tmr_count[0]) |=> o_pin_out[4] ==
		(($past(o_tmr_count[0]) == $past(o_ch_value[4])) ? 1'b1 : $past(o_tmr_ovf[0]) ? 1'b0 : $past(o_pin_out[4])); endproperty
	a_cmp3: assert property (p_cmp3) else $error("set and clear pin wrong");
	c_ovf: cover property (o_tmr_ovf[0]);
	c_cap: cover property (o_ch_irq[0]);
	c_pins: cover property (o_pin_out[4] && o_pin_out[5]);
endmodule // dcca_array_asserts

bind dcca_array dcca_array_asserts u_chk (.i_sys_clk, .i_nrst, .i_tmr_cfg, .i_ch_cfg, .i_gt6_ovf, .i_pin_in,
	.o_pin_out, .o_pin_oe_n, .o_ch_value, .o_ch_irq, .o_tmr_count, .o_tmr_ovf);

// ### testbench/dcca_far_side.sv
// far side model: pin levels and timer-six overflow pulses
`timescale 1ns/100ps
module dcca_far_side (
	input  wire logic        i_sys_clk,
	input  wire logic [31:0] i_dev_out,
	input  wire logic [31:0] i_dev_oe_n,
	input  wire logic [31:0] i_far_lvl,
	output logic      [31:0] o_pin,
	output logic             o_gt6_ovf
);
	// ------------------------------------------------------------
	// pins and pulses
	// ------------------------------------------------------------
	initial o_gt6_ovf = 1'b0;
	// the device wins where it drives, the far side elsewhere
	assign o_pin = (~i_dev_oe_n & i_dev_out) | (i_dev_oe_n & i_far_lvl);
	// n one-cycle pulses; gap 0 gives back-to-back ticks, larger gaps a slow source
	task automatic pulse(input int n, input int gap);
		repeat (n)
		begin
			o_gt6_ovf <= 1'b1;
			@(posedge i_sys_clk);
			if (gap != 0)
			begin
				o_gt6_ovf <= 1'b0;
				repeat (gap) @(posedge i_sys_clk);
			end
		end
		o_gt6_ovf <= 1'b0;
	endtask
endmodule // dcca_far_side

// ### testbench/dcca_array_tb.sv
// self-checking bench for the capture/compare array
`timescale 1ns/100ps
module dcca_array_tb;
	typedef struct packed { logic [4:0] ch; logic [15:0] val; } dcca_note_t;
	localparam logic [15:0] RLD = 16'hFFF0;  // short period after the first wrap
	logic clk = 1'b0;
	logic nrst = 1'b0;
	dcca_pkg::dcca_tmr_cfg_t [3:0]  tcfg;
	dcca_pkg::dcca_ch_cfg_t  [31:0] ccfg;
	logic [31:0] wr, lvl, pin, pout, poe_n, irq;
	logic [15:0] wdata, cnt, v;
	logic [31:0][15:0] cval;
	logic [3:0][15:0]  tcnt;
	logic [3:0]  tovf;
	logic gt6;
	logic [15:0] dbl;  // double register pair enables
	logic [1:0]  ext;  // external count inputs
	dcca_note_t q[$];  // expected interrupts, oldest first
	dcca_note_t nt;
	int seed, failures, checked;
	always #50 clk = ~clk;
	// ------------------------------------------------------------
	// design and far side
	// ------------------------------------------------------------
	dcca_array dut (.i_sys_clk(clk), .i_nrst(nrst), .i_tmr_cfg(tcfg), .i_ch_cfg(ccfg), .i_dbl_en(dbl),
		.i_ch_wr(wr), .i_ch_wr_data(wdata), .i_gt6_ovf(gt6), .i_ext_cnt(ext), .i_pin_in(pin),
		.o_pin_out(pout), .o_pin_oe_n(poe_n), .o_ch_value(cval), .o_ch_irq(irq), .o_tmr_count(tcnt), .o_tmr_ovf(tovf));
	dcca_far_side far (.i_sys_clk(clk), .i_dev_out(pout), .i_dev_oe_n(poe_n), .i_far_lvl(lvl), .o_pin(pin),
		.o_gt6_ovf(gt6));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ticks of timer a, tracked with wrap to the reload value
	task automatic tick(input int n, input int gap);
		far.pulse(n, gap);
		repeat (n) cnt = (cnt == 16'hFFFF) ? RLD : cnt + 16'h0001;
		repeat (3) @(posedge clk);
	endtask
	task automatic setp(input int i, input logic b);
		@(posedge clk);
		lvl[i] <= b;
		repeat (3) @(posedge clk);
	endtask
	// leading edge keeps strobes of two writes apart
	task automatic wrc(input int i, input logic [15:0] d);
		@(posedge clk);
		wdata <= d;
		wr <= 32'h1 << i;
		@(posedge clk);
		wr <= '0;
	endtask
	// bounded wait until every expected interrupt has been seen
	task automatic drain();
		for (int k = 0; k < 40 && q.size() != 0; k++) @(posedge clk);
		if (q.size() != 0)
		begin
			failures++;
			$display("ERROR drain expected 0 seen %0d", q.size());
			end_sim();
		end
	endtask
	// ------------------------------------------------------------
	// monitor: each interrupt takes the oldest note
	// ------------------------------------------------------------
	always @(negedge clk)
	begin
		for (int i = 0; i < 32; i++)
			if (irq[i] === 1'b1)
			begin
				if (q.size() == 0)
					chk("unexpected irq", 32'hFFFF, i);
				else
				begin
					nt = q.pop_front();
					chk("irq channel", nt.ch, 5'(i));
					chk("channel value", nt.val, cval[i]);
				end
			end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'h6d714718;
		wr = '0;
		wdata = '0;
		lvl = '0;
		cnt = '0;
		for (int i = 0; i < 32; i++) ccfg[i] = '{dcca_pkg::DCCA_OFF, 1'b0};
		ccfg[0].mode = dcca_pkg::DCCA_CAP_RISE;
		ccfg[1].mode = dcca_pkg::DCCA_CAP_FALL;
		ccfg[2].mode = dcca_pkg::DCCA_CAP_BOTH;
		ccfg[3].mode = dcca_pkg::DCCA_CMP0;
		ccfg[4].mode = dcca_pkg::DCCA_CMP3;
		ccfg[5].mode = dcca_pkg::DCCA_CMP1;
		// pair 6 with 14 drives pin 6; channel 14 sits on an unreached value
		ccfg[6].mode = dcca_pkg::DCCA_CMP0;
		ccfg[14].mode = dcca_pkg::DCCA_CMP0;
		ccfg[7].mode = dcca_pkg::DCCA_CMP2;
		dbl = 16'h0040;
		ext = 2'h0;
		tcfg[0] = '{1'b1, dcca_pkg::DCCA_SRC_GT6, 3'h0, RLD};
		tcfg[1] = '{1'b1, dcca_pkg::DCCA_SRC_PSC, 3'h0, 16'h0000};
		// unit one counts its external input; timer b must ignore it
		tcfg[2] = '{1'b1, dcca_pkg::DCCA_SRC_EXT, 3'h0, 16'h0000};
		tcfg[3] = tcfg[2];
		repeat (6) @(posedge clk);
		chk("released pins", 32'hFFFFFFFF, poe_n);
		nrst <= 1'b1;
		tick(3, 2);
		chk("timer count", cnt, tcnt[0]);
		// captures: rise, ignored rise on fall-only, fall, both edges
		q.push_back('{5'd0, cnt}); setp(0, 1'b1);
		setp(1, 1'b1);
		q.push_back('{5'd1, cnt}); setp(1, 1'b0);
		q.push_back('{5'd2, cnt}); setp(2, 1'b1);
		tick(1, 1);
		q.push_back('{5'd2, cnt}); setp(2, 1'b0);
		setp(0, 1'b0);
		drain();
		// compare values spread inside the short period
		v = 16'hFFF1 + 16'($random(seed) & 7);
		wrc(3, v);
		wrc(5, v + 16'h0002);
		wrc(4, v + 16'h0004);
		wrc(6, v + 16'h0001);
		for (int p = 0; p < 2; p++)
		begin
			wrc(7, v + 16'h0003);
			q.push_back('{5'd3, v});
			q.push_back('{5'd6, v + 16'h0001});
			q.push_back('{5'd5, v + 16'h0002});
			q.push_back('{5'd7, v + 16'h0003});
			q.push_back('{5'd4, v + 16'h0004});
			tick(16'(v + 16'h0003) - cnt, 0);
			// a second match later in the same period must stay silent
			wrc(7, v + 16'h0005);
			tick(16'hFFFF - cnt, 0);
			drain();
			chk("set pin", 32'h1, pout[4]);
			chk("toggle pin", p == 0, pout[5]);
			chk("double pin", p == 0, pout[6]);
			chk("double enables", 32'h2, {poe_n[14], poe_n[6]});
			tick(1, 1);
			chk("reloaded count", RLD, tcnt[0]);
			chk("cleared pin", 32'h0, pout[4]);
		end
		drain();
		// three rising edges on unit one's external count input
		repeat (3)
		begin
			@(posedge clk);
			ext <= 2'h2;
			@(posedge clk);
			ext <= 2'h0;
		end
		repeat (3) @(posedge clk);
		chk("external count a", 32'h3, tcnt[2]);
		chk("external count b", 32'h0, tcnt[3]);
		end_sim();
	end
endmodule // dcca_array_tb
